// ==== ifeb_bank.sv ====
// Interrupt flag and enable bank with an AXI4-Lite register slave
`timescale 1ns/100ps
`default_nettype none

module ifeb_bank
    import ifeb_pkg::*;
#(
    parameter int ADDR_W = 8                          // Register address width
) (
    input  wire logic              core_clk_in,       // System clock, 10 MHz
    input  wire logic              rstn_in,           // Synchronous reset, active low
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,   // Write address
    input  wire logic              s_axi_awvalid_in,  // Write address valid
    output logic                   s_axi_awready_out, // Write address ready
    input  wire logic [31:0]       s_axi_wdata_in,    // Write data
    input  wire logic [3:0]        s_axi_wstrb_in,    // Write byte strobes
    input  wire logic              s_axi_wvalid_in,   // Write data valid
    output logic                   s_axi_wready_out,  // Write data ready
    output logic [1:0]             s_axi_bresp_out,   // Write response
    output logic                   s_axi_bvalid_out,  // Write response valid
    input  wire logic              s_axi_bready_in,   // Write response ready
    input  wire logic [ADDR_W-1:0] s_axi_araddr_in,   // Read address
    input  wire logic              s_axi_arvalid_in,  // Read address valid
    output logic                   s_axi_arready_out, // Read address ready
    output logic [31:0]            s_axi_rdata_out,   // Read data
    output logic [1:0]             s_axi_rresp_out,   // Read response
    output logic                   s_axi_rvalid_out,  // Read data valid
    input  wire logic              s_axi_rready_in,   // Read data ready
    input  wire logic [15:0]       src_flags_three_in,// Source request pulses, word three
    input  wire logic [15:0]       src_flags_four_in, // Source request pulses, word four
    input  wire logic [15:0]       ext_flags_zero_in, // Flag word 0 held outside
    input  wire logic [15:0]       ext_flags_one_in,  // Flag word 1 held outside
    input  wire logic [15:0]       ext_flags_two_in,  // Flag word 2 held outside
    input  wire logic [15:0]       ext_enables_three_in, // Enable word 3 held outside
    input  wire logic [15:0]       ext_enables_four_in,  // Enable word 4 held outside
    output logic [15:0]            enables_zero_out,  // Enable word 0
    output logic [15:0]            enables_one_out,   // Enable word 1
    output logic [15:0]            enables_two_out,   // Enable word 2
    output logic [15:0]            flags_three_out,   // Flag word three
    output logic [15:0]            flags_four_out,    // Flag word four
    output logic [2:0]             core_req_level_out,// Highest pending priority, 0 = none
    output logic [2:0]             core_req_bank_out, // Bank that holds that request
    output logic                   irq_out            // Summary interrupt, level
);

    // Merge a bus write into a 16-bit register under byte strobes and mask
    function automatic logic [15:0] merge16(input logic [15:0] old_val,
                                            input logic [31:0] wdata,
                                            input logic [3:0]  wstrb,
                                            input logic [15:0] mask);
        logic [15:0] val;
        val = old_val;
        if (wstrb[0]) begin
            val[7:0] = wdata[7:0];
        end
        if (wstrb[1]) begin
            val[15:8] = wdata[15:8];
        end
        return val & mask;
    endfunction : merge16

    // A priority field asks for service only when it is not the off code
    function automatic logic prio_live(input logic [2:0] code);
        return code != PRIO_OFF;
    endfunction : prio_live

    // Register state
    logic [15:0]       flags_three_reg;
    logic [15:0]       flags_three_next;
    logic [15:0]       flags_four_reg;
    logic [15:0]       flags_four_next;
    logic [15:0]       enables_zero_reg;
    logic [15:0]       enables_zero_next;
    logic [15:0]       enables_one_reg;
    logic [15:0]       enables_one_next;
    logic [15:0]       enables_two_reg;
    logic [15:0]       enables_two_next;
    logic [14:0]       priority_reg;
    logic [14:0]       priority_next;
    logic [4:0]        irq_status_reg;
    logic [4:0]        irq_status_next;
    logic [4:0]        irq_mask_reg;
    logic [4:0]        irq_mask_next;
    logic [4:0]        pend_reg;
    logic [4:0]        pend_next;
    logic [2:0]        level_reg;
    logic [2:0]        level_next;
    logic [2:0]        bank_reg;
    logic [2:0]        bank_next;

    // Bus state
    logic              aw_held_reg;
    logic              aw_held_next;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [ADDR_W-1:0] aw_addr_next;
    logic              w_held_reg;
    logic              w_held_next;
    logic [31:0]       w_data_reg;
    logic [31:0]       w_data_next;
    logic [3:0]        w_strb_reg;
    logic [3:0]        w_strb_next;
    logic              bvalid_reg;
    logic              bvalid_next;
    logic [1:0]        bresp_reg;
    logic [1:0]        bresp_next;
    logic              rvalid_reg;
    logic              rvalid_next;
    logic [31:0]       rdata_reg;
    logic [31:0]       rdata_next;
    logic [1:0]        rresp_reg;
    logic [1:0]        rresp_next;

    logic              wr_go;
    logic              rd_go;
    logic [7:0]        wr_ofs;
    logic [7:0]        rd_ofs;
    logic [4:0]        pend_now;

    // Handshake readiness and the moments a write or read is carried out
    assign s_axi_awready_out = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready_out  = !w_held_reg && !bvalid_reg;
    assign s_axi_arready_out = !rvalid_reg;
    assign wr_go             = aw_held_reg && w_held_reg && !bvalid_reg;
    assign rd_go             = s_axi_arvalid_in && !rvalid_reg;
    assign wr_ofs            = 8'(aw_addr_reg);
    assign rd_ofs            = 8'(s_axi_araddr_in);

    // Write channel capture, taken in either order
    always_comb begin
        aw_held_next = aw_held_reg;
        aw_addr_next = aw_addr_reg;
        w_held_next  = w_held_reg;
        w_data_next  = w_data_reg;
        w_strb_next  = w_strb_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_held_next = 1'b1;
            aw_addr_next = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_held_next = 1'b1;
            w_data_next = s_axi_wdata_in;
            w_strb_next = s_axi_wstrb_in;
        end
        if (wr_go) begin
            aw_held_next = 1'b0;
            w_held_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = (wr_ofs <= OFS_IRQ_MASK && wr_ofs[1:0] == 2'h0 &&
                            wr_ofs != OFS_IRQ_STATUS) ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_reg && s_axi_bready_in) begin
            bvalid_next = 1'b0;
        end
    end

    // Read channel: data registered on the edge that takes the address
    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        if (rd_go) begin
            rvalid_next = 1'b1;
            rresp_next  = RESP_OKAY;
            rdata_next  = 32'h0000_0000;
            case (rd_ofs)
                OFS_FLAGS_THREE: rdata_next[15:0] = flags_three_reg;
                OFS_FLAGS_FOUR:  rdata_next[15:0] = flags_four_reg;
                OFS_ENABLES_0:   rdata_next[15:0] = enables_zero_reg;
                OFS_ENABLES_1:   rdata_next[15:0] = enables_one_reg;
                OFS_ENABLES_2:   rdata_next[15:0] = enables_two_reg;
                OFS_PRIORITY:    rdata_next[14:0] = priority_reg;
                OFS_IRQ_STATUS:  rdata_next[4:0]  = irq_status_reg;
                OFS_IRQ_MASK:    rdata_next[4:0]  = irq_mask_reg;
                OFS_PENDING:     rdata_next[4:0]  = pend_reg;
                default:         rresp_next       = RESP_SLVERR;
            endcase
        end else if (rvalid_reg && s_axi_rready_in) begin
            rvalid_next = 1'b0;
        end
    end

    // Flag words: a source pulse sets, software writes any value, set wins
    always_comb begin
        flags_three_next = flags_three_reg;
        flags_four_next  = flags_four_reg;
        if (wr_go && wr_ofs == OFS_FLAGS_THREE) begin
            flags_three_next = merge16(flags_three_reg, w_data_reg, w_strb_reg,
                                       MASK_FLAGS_THREE);
        end
        if (wr_go && wr_ofs == OFS_FLAGS_FOUR) begin
            flags_four_next = merge16(flags_four_reg, w_data_reg, w_strb_reg,
                                      MASK_FLAGS_FOUR);
        end
        flags_three_next = (flags_three_next | src_flags_three_in)
                           & MASK_FLAGS_THREE;
        flags_four_next  = (flags_four_next | src_flags_four_in)
                           & MASK_FLAGS_FOUR;
    end

    // Enable words and the priority register, written by software only
    always_comb begin
        enables_zero_next = enables_zero_reg;
        enables_one_next  = enables_one_reg;
        enables_two_next  = enables_two_reg;
        priority_next     = priority_reg;
        irq_mask_next     = irq_mask_reg;
        if (wr_go) begin
            case (wr_ofs)
                OFS_ENABLES_0: enables_zero_next = merge16(enables_zero_reg, w_data_reg,
                                   w_strb_reg, MASK_ENABLES_0);
                OFS_ENABLES_1: enables_one_next = merge16(enables_one_reg, w_data_reg,
                                   w_strb_reg, MASK_ENABLES_1);
                OFS_ENABLES_2: enables_two_next = merge16(enables_two_reg, w_data_reg,
                                   w_strb_reg, MASK_ENABLES_2);
                OFS_PRIORITY: begin
                    if (w_strb_reg[0]) begin
                        priority_next[7:0] = w_data_reg[7:0];
                    end
                    if (w_strb_reg[1]) begin
                        priority_next[14:8] = w_data_reg[14:8];
                    end
                end
                OFS_IRQ_MASK: begin
                    if (w_strb_reg[0]) begin
                        irq_mask_next = w_data_reg[4:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Per-bank pending: a flag counts only where its enable is set
    always_comb begin
        pend_now[BANK_EN0]    = |(ext_flags_zero_in & enables_zero_reg);
        pend_now[BANK_EN1]    = |(ext_flags_one_in & enables_one_reg);
        pend_now[BANK_EN2]    = |(ext_flags_two_in & enables_two_reg);
        pend_now[BANK_FLAGS3] = |(flags_three_reg & ext_enables_three_in);
        pend_now[BANK_FLAGS4] = |(flags_four_reg & ext_enables_four_in);
        pend_next             = pend_now;
    end

    // Highest live priority among pending banks goes to the core
    always_comb begin
        logic [2:0] code;
        code       = PRIO_OFF;
        level_next = PRIO_OFF;
        bank_next  = 3'h0;
        for (int b = 0; b < NUM_BANKS; b++) begin
            code = priority_reg[b*PRIO_W +: PRIO_W];
            if (pend_now[b] && prio_live(code) && code > level_next) begin
                level_next = code;
                bank_next  = 3'(b);
            end
        end
    end

    // Sticky event status: a newly pending bank sets, a read clears, set wins
    always_comb begin
        irq_status_next = irq_status_reg;
        if (rd_go && rd_ofs == OFS_IRQ_STATUS) begin
            irq_status_next = RST_IRQ;
        end
        irq_status_next = irq_status_next | (pend_now & ~pend_reg);
    end

    // Registers
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            flags_three_reg  <= RST_REG16;
            flags_four_reg   <= RST_REG16;
            enables_zero_reg <= RST_REG16;
            enables_one_reg  <= RST_REG16;
            enables_two_reg  <= RST_REG16;
            priority_reg     <= RST_PRIORITY;
            irq_status_reg   <= RST_IRQ;
            irq_mask_reg     <= RST_IRQ;
            pend_reg         <= RST_IRQ;
            level_reg        <= PRIO_OFF;
            bank_reg         <= 3'h0;
            aw_held_reg      <= 1'b0;
            aw_addr_reg      <= '0;
            w_held_reg       <= 1'b0;
            w_data_reg       <= 32'h0000_0000;
            w_strb_reg       <= 4'h0;
            bvalid_reg       <= 1'b0;
            bresp_reg        <= RESP_OKAY;
            rvalid_reg       <= 1'b0;
            rdata_reg        <= 32'h0000_0000;
            rresp_reg        <= RESP_OKAY;
        end else begin
            flags_three_reg  <= flags_three_next;
            flags_four_reg   <= flags_four_next;
            enables_zero_reg <= enables_zero_next;
            enables_one_reg  <= enables_one_next;
            enables_two_reg  <= enables_two_next;
            priority_reg     <= priority_next;
            irq_status_reg   <= irq_status_next;
            irq_mask_reg     <= irq_mask_next;
            pend_reg         <= pend_next;
            level_reg        <= level_next;
            bank_reg         <= bank_next;
            aw_held_reg      <= aw_held_next;
            aw_addr_reg      <= aw_addr_next;
            w_held_reg       <= w_held_next;
            w_data_reg       <= w_data_next;
            w_strb_reg       <= w_strb_next;
            bvalid_reg       <= bvalid_next;
            bresp_reg        <= bresp_next;
            rvalid_reg       <= rvalid_next;
            rdata_reg        <= rdata_next;
            rresp_reg        <= rresp_next;
        end
    end

    // Outputs
    assign s_axi_bvalid_out   = bvalid_reg;
    assign s_axi_bresp_out    = bresp_reg;
    assign s_axi_rvalid_out   = rvalid_reg;
    assign s_axi_rdata_out    = rdata_reg;
    assign s_axi_rresp_out    = rresp_reg;
    assign enables_zero_out   = enables_zero_reg;
    assign enables_one_out    = enables_one_reg;
    assign enables_two_out    = enables_two_reg;
    assign flags_three_out    = flags_three_reg;
    assign flags_four_out     = flags_four_reg;
    assign core_req_level_out = level_reg;
    assign core_req_bank_out  = bank_reg;
    assign irq_out            = |(irq_status_reg & irq_mask_reg);

endmodule : ifeb_bank

`default_nettype wire

// ==== ifeb_bank_assertions.sv ====
// Concurrent checks on the ports of the interrupt flag and enable bank
`timescale 1ns/100ps
`default_nettype none
module ifeb_bank_assertions
    import ifeb_pkg::*;
(
    input wire logic        core_clk_in, rstn_in,                   // Clock, reset
    input wire logic        s_axi_arvalid_in, s_axi_arready_out,    // Read address
    input wire logic        s_axi_rvalid_out, s_axi_rready_in,      // Read data
    input wire logic        s_axi_bvalid_out, s_axi_bready_in,      // Write response
    input wire logic        irq_out,                                // Summary interrupt
    input wire logic [1:0]  s_axi_bresp_out,                        // Write response code
    input wire logic [2:0]  core_req_level_out, core_req_bank_out,  // Request to core
    input wire logic [15:0] src_flags_four_in, ext_enables_four_in, // Word four inputs
    input wire logic [15:0] flags_three_out, flags_four_out,        // Flag words
    input wire logic [15:0] enables_zero_out                        // Enable word 0
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    // Flag words, reserved bits and reset
    a_flag_source_sets: assert property ((src_flags_four_in & MASK_FLAGS_FOUR) != 16'h0000
        |=> (flags_four_out & $past(src_flags_four_in) & MASK_FLAGS_FOUR)
            == ($past(src_flags_four_in) & MASK_FLAGS_FOUR)) else $error("flag not set");
    a_unused_zero: assert property ((flags_three_out & ~MASK_FLAGS_THREE) == 16'h0000
        && (flags_four_out & ~MASK_FLAGS_FOUR) == 16'h0000
        && (enables_zero_out & ~MASK_ENABLES_0) == 16'h0000) else $error("reserved bit set");
    a_reset_clears: assert property (disable iff (1'b0) !rstn_in |=>
        {flags_three_out, flags_four_out, enables_zero_out} == 48'h0) else $error("no reset");
    a_flag_sticky: assert property ($past(rstn_in)
        && (~flags_four_out & $past(flags_four_out)) != 16'h0000 |-> s_axi_bvalid_out)
        else $error("flag cleared without write");
    // Request to the core needs flag and enable together
    a_bank4_pending: assert property (core_req_level_out != 3'h0 && core_req_bank_out == 3'h4
        |-> ($past(flags_four_out) & $past(ext_enables_four_in)) != 16'h0000)
        else $error("request without flag and enable");
    // Register bus answers and holds them
    a_read_answers: assert property (s_axi_arvalid_in && s_axi_arready_out |=>
        s_axi_rvalid_out) else $error("read not answered");
    a_rvalid_holds: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
        s_axi_rvalid_out) else $error("read data dropped");
    a_bresp_holds: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
        s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write response dropped");
    c_irq_raised: cover property ($rose(irq_out));
    c_refused: cover property (s_axi_bvalid_out && s_axi_bresp_out == RESP_SLVERR);
    c_top_level: cover property (core_req_level_out == 3'h7);
endmodule : ifeb_bank_assertions

bind ifeb_bank ifeb_bank_assertions u_chk (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
    .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
    .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
    .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
    .irq_out(irq_out), .s_axi_bresp_out(s_axi_bresp_out),
    .core_req_level_out(core_req_level_out), .core_req_bank_out(core_req_bank_out),
    .src_flags_four_in(src_flags_four_in), .ext_enables_four_in(ext_enables_four_in),
    .flags_three_out(flags_three_out), .flags_four_out(flags_four_out),
    .enables_zero_out(enables_zero_out));
`default_nettype wire

// ==== ifeb_bank_test.sv ====
// Self-checking bench for the interrupt flag and enable bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module ifeb_bank_test;
    import ifeb_pkg::*;
    logic        clk, rstn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata;
    logic [15:0] cmd3, cmd4, src3, src4, xf0, xe4;
    wire logic        awready, wready, bvalid, arready, rvalid, irq;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [15:0] en0, en1, en2, fl3, fl4;
    wire logic [2:0]  lvl, bank;
    int          error_cnt, cmp_count;
    ifeb_bank dut (.core_clk_in(clk), .rstn_in(rstn), .s_axi_awaddr_in(awaddr),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .src_flags_three_in(src3), .src_flags_four_in(src4),
        .ext_flags_zero_in(xf0), .ext_flags_one_in(16'h0000), .ext_flags_two_in(16'h0000),
        .ext_enables_three_in(16'h0000), .ext_enables_four_in(xe4), .enables_zero_out(en0),
        .enables_one_out(en1), .enables_two_out(en2), .flags_three_out(fl3), .flags_four_out(fl4),
        .core_req_level_out(lvl), .core_req_bank_out(bank), .irq_out(irq));
    ifeb_src_model u_src (.clk_in(clk), .rstn_in(rstn), .cmd_three_in(cmd3),
        .cmd_four_in(cmd4), .req_three_out(src3), .req_four_out(src4));
    always #50 clk = ~clk;
    // Bus write: both channels offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b1;
        do @(posedge clk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    // Bus read
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b1;
        do @(posedge clk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
    // Reset values, access, reserved bits and refused addresses
    task automatic t_regs();
        logic [7:0]  ofs [5] = '{OFS_FLAGS_THREE, OFS_FLAGS_FOUR, OFS_ENABLES_0,
                                 OFS_ENABLES_1, OFS_ENABLES_2};
        logic [15:0] msk [5] = '{16'h0003, 16'h00F7, 16'h7FFF, 16'hFFFB, 16'hDFFF};
        logic [31:0] d;
        logic [1:0]  r;
        for (int i = 0; i < 5; i++) begin
            rd(ofs[i], d, r);
            `CHK(d, 32'h0000_0000)
            wr(ofs[i], 32'hFFFF_FFFF, r);
            `CHK({r, 16'({en2, en1, en0, fl4, fl3} >> (16 * i))}, {RESP_OKAY, msk[i]})
            rd(ofs[i], d, r);
            `CHK(d, {16'h0000, msk[i]})
            wr(ofs[i], 32'h0000_0000, r);
            rd(ofs[i], d, r);
            `CHK({r, d}, {RESP_OKAY, 32'h0000_0000})
        end
        rd(8'h24, d, r);
        `CHK({r, d}, {RESP_SLVERR, 32'h0000_0000})
        wr(OFS_IRQ_STATUS, 32'h0000_001F, r);
        `CHK(r, RESP_SLVERR)
        $display("t_regs done");
    endtask : t_regs
    // Each source sets its own flag, which stays until written back
    task automatic t_src();
        logic [1:0] r;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            cmd4 <= 16'h0001 << i;
            cmd3 <= 16'h0001 << i;
            repeat (6) @(posedge clk);
            #1;
            `CHK(fl4, (i == 3) ? 16'h0000 : 16'h0001 << i)
            `CHK(fl3, (i > 1) ? 16'h0000 : 16'h0001 << i)
            @(posedge clk);
            cmd4 <= 16'h0000;
            cmd3 <= 16'h0000;
            wr(OFS_FLAGS_FOUR, 32'h0000_0000, r);
            wr(OFS_FLAGS_THREE, 32'h0000_0000, r);
            `CHK({fl3, fl4}, 32'h0000_0000)
        end
        $display("t_src done");
    endtask : t_src
    // Enable gating, priority codes, interrupt and read-clear status
    task automatic t_irq();
        logic [31:0] d;
        logic [1:0]  r;
        wr(OFS_IRQ_MASK, 32'h0000_0010, r);
        @(posedge clk);
        cmd4 <= 16'h0080;
        repeat (5) @(posedge clk);
        #1;
        `CHK({irq, lvl}, 4'h0)
        @(posedge clk);
        xe4 <= 16'h0080;
        repeat (3) @(posedge clk);
        #1;
        `CHK({irq, lvl, bank}, 7'h64)
        wr(OFS_PRIORITY, 32'h0000_7924, r);
        repeat (2) @(posedge clk);
        #1;
        `CHK(lvl, 3'h7)
        wr(OFS_PRIORITY, 32'h0000_0924, r);
        repeat (2) @(posedge clk);
        #1;
        `CHK(lvl, 3'h0)
        rd(OFS_IRQ_STATUS, d, r);
        `CHK(d, 32'h0000_0010)
        repeat (2) @(posedge clk);
        #1;
        `CHK(irq, 1'b0)
        @(posedge clk);
        xf0 <= 16'h0001;
        wr(OFS_ENABLES_0, 32'h0000_0001, r);
        repeat (2) @(posedge clk);
        #1;
        `CHK({en0, lvl, bank}, 22'h0_0060)
        wr(OFS_ENABLES_0, 32'h0000_0000, r);
        repeat (2) @(posedge clk);
        #1;
        `CHK(lvl, 3'h0)
        $display("t_irq done");
    endtask : t_irq
    // Print counts and verdict, then stop
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize
    // Main sequence
    initial begin
        {clk, rstn, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
        {awaddr, araddr, wdata, cmd3, cmd4, xf0, xe4} = '0;
        error_cnt = 0;
        cmp_count = 0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_src();
        t_irq();
        summarize();
    end
    // Watchdog, well beyond the few hundred cycles the tests need
    initial begin
        #500_000;
        error_cnt++;
        summarize();
    end
endmodule : ifeb_bank_test
`default_nettype wire

// ==== ifeb_pkg.sv ====
// Package: register map, field layout and reset values of the interrupt flag/enable bank
package ifeb_pkg;
    // Bus and register geometry
    localparam int          AXI_DATA_W   = 32;
    localparam int          REG_W        = 16;
    localparam int          NUM_BANKS    = 5;
    localparam int          PRIO_W       = 3;
    localparam int          PRIO_REG_W   = NUM_BANKS * PRIO_W;
    // Byte offsets of the registers
    localparam logic [7:0]  OFS_FLAGS_THREE = 8'h00;
    localparam logic [7:0]  OFS_FLAGS_FOUR  = 8'h04;
    localparam logic [7:0]  OFS_ENABLES_0   = 8'h08;
    localparam logic [7:0]  OFS_ENABLES_1   = 8'h0C;
    localparam logic [7:0]  OFS_ENABLES_2   = 8'h10;
    localparam logic [7:0]  OFS_PRIORITY    = 8'h14;
    localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h18;
    localparam logic [7:0]  OFS_IRQ_MASK    = 8'h1C;
    localparam logic [7:0]  OFS_PENDING     = 8'h20;
    // Implemented-bit masks; every other bit reads zero and ignores writes
    localparam logic [15:0] MASK_FLAGS_THREE = 16'h0003;
    localparam logic [15:0] MASK_FLAGS_FOUR  = 16'h00F7;
    localparam logic [15:0] MASK_ENABLES_0   = 16'h7FFF;
    localparam logic [15:0] MASK_ENABLES_1   = 16'hFFFB;
    localparam logic [15:0] MASK_ENABLES_2   = 16'hDFFF;
    // Flag bit positions in the third and fourth flag words
    localparam int          TWI2_SLAVE_EVENT_FLAG_POS = 1;
    localparam int          TIMER7_FLAG_POS           = 0;
    localparam int          CAN2_TX_REQUEST_FLAG_POS  = 7;
    localparam int          CAN1_TX_REQUEST_FLAG_POS  = 6;
    localparam int          DMA_CH7_DONE_FLAG_POS     = 5;
    localparam int          DMA_CH6_DONE_FLAG_POS     = 4;
    localparam int          UART2_ERROR_FLAG_POS      = 2;
    localparam int          UART1_ERROR_FLAG_POS      = 1;
    localparam int          PWM_FAULT_B_FLAG_POS      = 0;
    // Reset values
    localparam logic [15:0] RST_REG16     = 16'h0000;
    localparam logic [2:0]  PRIO_OFF      = 3'h0;
    localparam logic [2:0]  PRIO_RST      = 3'h4;
    localparam logic [14:0] RST_PRIORITY  = 15'h4924;
    localparam logic [4:0]  RST_IRQ       = 5'h00;
    // Bank numbering: enable words 0..2, flag words three and four
    localparam int          BANK_EN0      = 0;
    localparam int          BANK_EN1      = 1;
    localparam int          BANK_EN2      = 2;
    localparam int          BANK_FLAGS3   = 3;
    localparam int          BANK_FLAGS4   = 4;
    // Bus responses
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage : ifeb_pkg

// ==== ifeb_src_model.sv ====
// Peripheral source model: each command rise becomes one request pulse
`timescale 1ns/100ps
`default_nettype none
module ifeb_src_model (
    input  wire logic        clk_in,        // System clock
    input  wire logic        rstn_in,       // Reset, active low
    input  wire logic [15:0] cmd_three_in,  // Request commands, word three
    input  wire logic [15:0] cmd_four_in,   // Request commands, word four
    output logic      [15:0] req_three_out, // Request pulses, word three
    output logic      [15:0] req_four_out   // Request pulses, word four
);
    logic [15:0] last_three_reg, last_four_reg;
    // A peripheral raises one event per command, not a level
    always_ff @(posedge clk_in) begin
        last_three_reg <= rstn_in ? cmd_three_in : 16'h0000;
        last_four_reg  <= rstn_in ? cmd_four_in : 16'h0000;
        req_three_out  <= rstn_in ? (cmd_three_in & ~last_three_reg) : 16'h0000;
        req_four_out   <= rstn_in ? (cmd_four_in & ~last_four_reg) : 16'h0000;
    end
endmodule : ifeb_src_model
`default_nettype wire
